/* File: hw/tdg_cfg.svh */
// Timing and size constants for the torque disable gate
`ifndef TDG_CFG_SVH
`define TDG_CFG_SVH
`define TDG_CLK_HZ 100000000
`define TDG_PULSE_LIMIT_US 1000
`define TDG_RESPONSE_MAX_US 20000
// Least time: a low pulse up to the limit must be ignored, so filter strictly longer (round up)
`define TDG_PULSE_CYCLES ((`TDG_PULSE_LIMIT_US * (`TDG_CLK_HZ / 1000000)) + 1)
// Longest time: rounds down
`define TDG_RESPONSE_CYCLES (`TDG_RESPONSE_MAX_US * (`TDG_CLK_HZ / 1000000))
`define TDG_NUM_CHAN 2
`define TDG_NUM_SW 6
`endif

/* File: hw/tdg_pkg.sv */
// Types shared by the torque disable gate modules
package tdg_pkg;
    typedef enum logic [1:0] {
        TDG_OFF = 2'b00,
        TDG_ON = 2'b01,
        TDG_DIP = 2'b10
    } tdg_state_e;
endpackage

/* File: hw/tdg_filt_if.sv */
// Carrier between the gate top and its per-channel filter
`timescale 1ns/1ns
interface tdg_filt_if;
    logic raw;
    logic filtered;
    logic stuck;
    modport top (output raw, input filtered, input stuck);
    modport filt (input raw, output filtered, output stuck);
endinterface

/* File: hw/tdg_filt.sv */
// Per-channel enable filter: ignores short low pulses, disables on sustained low
`timescale 1ns/1ns
`include "tdg_cfg.svh"
module tdg_filt
    import tdg_pkg::*;
#(
    parameter int PULSE_CYCLES = `TDG_PULSE_CYCLES,
    parameter int STUCK_CYCLES = 4 * `TDG_RESPONSE_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    tdg_filt_if.filt port_if
);
    localparam int CW = $clog2(STUCK_CYCLES + 1);
    tdg_state_e state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [CW-1:0] hi_ff, nxt_hi;
    logic out_ff, nxt_out;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_out = 1'b0;
        nxt_hi = hi_ff;
        case (state_ff)
            TDG_OFF: begin
                nxt_cnt = '0;
                if (port_if.raw) begin
                    nxt_state = TDG_ON;
                end
            end
            TDG_ON: begin
                nxt_out = 1'b1;
                nxt_cnt = '0;
                if (!port_if.raw) begin
                    nxt_state = TDG_DIP;
                end
            end
            TDG_DIP: begin
                // Hold enable through test pulses up to the limit
                nxt_out = 1'b1;
                if (port_if.raw) begin
                    nxt_state = TDG_ON;
                end else if (cnt_ff >= CW'(PULSE_CYCLES - 1)) begin
                    nxt_state = TDG_OFF;
                    nxt_out = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            default: begin
                // Unknown code fails safe
                nxt_state = TDG_OFF;
            end
        endcase
        // A high level that never shows a test pulse is treated as stuck
        if (!port_if.raw) begin
            nxt_hi = '0;
        end else if (hi_ff != CW'(STUCK_CYCLES)) begin
            nxt_hi = hi_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= TDG_OFF;
            cnt_ff <= '0;
            hi_ff <= '0;
            out_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            hi_ff <= nxt_hi;
            out_ff <= nxt_out;
        end
    end

    assign port_if.filtered = out_ff;
    assign port_if.stuck = (hi_ff == CW'(STUCK_CYCLES));
endmodule

/* File: hw/tdg_top.sv */
// Torque disable gate: filters enable channels and gates power-stage switching
`timescale 1ns/1ns
`include "tdg_cfg.svh"

module tdg_top
    import tdg_pkg::*;
#(
    parameter int NUM_CHAN = `TDG_NUM_CHAN,
    parameter int NUM_SW = `TDG_NUM_SW,
    parameter int PULSE_CYCLES = `TDG_PULSE_CYCLES,
    parameter int STUCK_CYCLES = 4 * `TDG_RESPONSE_CYCLES
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [NUM_CHAN-1:0] EN_IN,
    input wire logic [NUM_SW-1:0] SW_CMD,
    input wire logic MON_TO_DOUT,
    output logic [NUM_SW-1:0] SW_OUT,
    output logic DRV_SUPPLY_ON,
    output logic TORQUE_REMOVAL,
    output logic ENABLE_MON,
    output logic DOUT
);
    import tdg_pkg::*;

    logic [NUM_CHAN-1:0] sync1_ff, nxt_sync1;
    logic [NUM_CHAN-1:0] sync2_ff, nxt_sync2;
    logic [NUM_CHAN-1:0] filt;
    logic [NUM_CHAN-1:0] stuck;
    logic eff_en;
    logic gate_ff, nxt_gate;
    logic [NUM_SW-1:0] sw_ff, nxt_sw;
    logic mon_ff, nxt_mon;
    logic dout_ff, nxt_dout;

    ////////////////////////////////////////////////////////////////
    // Two-stage synchronisers; the pin is used as-is, active high
    always_comb begin
        nxt_sync1 = EN_IN;
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    ////////////////////////////////////////////////////////////////
    // One filter per channel
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            tdg_filt_if fif ();
            assign fif.raw = sync2_ff[gi];
            assign filt[gi] = fif.filtered;
            assign stuck[gi] = fif.stuck;
            tdg_filt #(
                .PULSE_CYCLES(PULSE_CYCLES),
                .STUCK_CYCLES(STUCK_CYCLES)
            ) u_filt (
                .clk(CLK),
                .resetn(RESETN),
                .port_if(fif)
            );
        end
    endgenerate

    // Any one channel low is enough; a stuck-high channel also blocks
    assign eff_en = (&filt) && !(|stuck);

    ////////////////////////////////////////////////////////////////
    // Gate every switching command; no software term enters here
    always_comb begin
        nxt_gate = eff_en;
        // Cleared in one cycle, no ramp and no braking pattern
        nxt_sw = eff_en ? SW_CMD : '0;
        nxt_mon = eff_en;
        // Optional feedback route; plain monitor, not a safety signal
        nxt_dout = MON_TO_DOUT & eff_en;
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            gate_ff <= 1'b0;
            sw_ff <= '0;
            mon_ff <= 1'b0;
            dout_ff <= 1'b0;
        end else begin
            gate_ff <= nxt_gate;
            sw_ff <= nxt_sw;
            mon_ff <= nxt_mon;
            dout_ff <= nxt_dout;
        end
    end

    // Output stage also ANDed with the supply so a stale register cannot pass commands
    assign SW_OUT = sw_ff & {NUM_SW{gate_ff}};
    assign DRV_SUPPLY_ON = gate_ff;
    assign TORQUE_REMOVAL = !gate_ff;
    assign ENABLE_MON = mon_ff;
    assign DOUT = dout_ff;
endmodule

/* File: verification/tdg_ctrl_model.sv */
// Safety controller model driving self-tested enable outputs
`timescale 1ns/1ns
module tdg_ctrl (
    input wire logic clk,
    input wire logic [1:0] on,
    input wire logic [7:0] pulse_w,
    output logic [1:0] en = 2'b00
);
    int cnt = 0;
    // Staggered test pulses; the period stays below the stuck limit
    always @(negedge clk) begin
        cnt <= (cnt + 1) % 100;
        en[0] <= on[0] && cnt >= pulse_w;
        en[1] <= on[1] && (cnt < 50 || cnt >= 50 + pulse_w);
    end
endmodule

/* File: verification/tdg_top_monitor.sv */
// Checker for the torque disable gate ports
`timescale 1ns/1ns
module tdg_mon #(parameter int NUM_CHAN = 2, parameter int NUM_SW = 6, parameter int PULSE_CYCLES = 20) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [NUM_CHAN-1:0] EN_IN,
    input wire logic [NUM_SW-1:0] SW_CMD,
    input wire logic MON_TO_DOUT,
    input wire logic [NUM_SW-1:0] SW_OUT,
    input wire logic DRV_SUPPLY_ON,
    input wire logic TORQUE_REMOVAL,
    input wire logic ENABLE_MON,
    input wire logic DOUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    int low_cnt;
    // Slack of a few edges covers the input synchroniser and gate register
    always_ff @(posedge CLK or negedge RESETN)
        if (!RESETN) low_cnt <= 0;
        else low_cnt <= (&EN_IN) ? 0 : low_cnt + 1;
    sequence off_s;
        !DRV_SUPPLY_ON && SW_OUT == '0;
    endsequence
    chk_gate_off: assert property (TORQUE_REMOVAL |-> off_s) else $error("switch leak");
    chk_stop_now: assert property ($fell(ENABLE_MON) |-> off_s) else $error("slow stop");
    chk_mon_state: assert property (ENABLE_MON == !TORQUE_REMOVAL) else $error("monitor wrong");
    chk_dout_map: assert property (DOUT |-> ENABLE_MON) else $error("dout wrong");
    chk_dout_off: assert property (!$past(MON_TO_DOUT) |-> !DOUT) else $error("dout unmapped");
    chk_sw_pass: assert property (DRV_SUPPLY_ON |-> SW_OUT == $past(SW_CMD)) else $error("sw wrong");
    chk_any_low: assert property (low_cnt > PULSE_CYCLES + 6 |-> TORQUE_REMOVAL) else $error("no disable");
    // The channel that completes enabling was sampled high five edges before the rise is seen here
    chk_rise_cause: assert property ($rose(DRV_SUPPLY_ON) |-> $past(EN_IN, 5) != '0) else $error("bad enable");
endmodule
bind tdg_top tdg_mon #(.NUM_CHAN(NUM_CHAN), .NUM_SW(NUM_SW), .PULSE_CYCLES(PULSE_CYCLES)) mon_u (.CLK(CLK),
    .RESETN(RESETN), .EN_IN(EN_IN), .SW_CMD(SW_CMD), .MON_TO_DOUT(MON_TO_DOUT), .SW_OUT(SW_OUT),
    .DRV_SUPPLY_ON(DRV_SUPPLY_ON), .TORQUE_REMOVAL(TORQUE_REMOVAL), .ENABLE_MON(ENABLE_MON), .DOUT(DOUT));

/* File: verification/torque_disable_gate_bench.sv */
// Bench for the torque disable gate
`timescale 1ns/1ns
module torque_disable_gate_bench;
    logic clk = 0;
    logic resetn = 0;
    logic [1:0] on = 0;
    logic [7:0] pw = 10;
    logic [5:0] cmd = 6'h2a;
    logic map = 1;
    logic [1:0] en;
    logic [5:0] sw;
    logic sup, rem, mon, dout;
    int failures = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    tdg_ctrl ctrl_u (.clk(clk), .on(on), .pulse_w(pw), .en(en));
    tdg_top #(.PULSE_CYCLES(20), .STUCK_CYCLES(200)) dut_u (.CLK(clk), .RESETN(resetn), .EN_IN(en), .SW_CMD(cmd),
        .MON_TO_DOUT(map), .SW_OUT(sw), .DRV_SUPPLY_ON(sup), .TORQUE_REMOVAL(rem), .ENABLE_MON(mon), .DOUT(dout));
    task chk(string what, logic [5:0] exp, logic [5:0] got);
        samples_checked++;
        if (exp !== got) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wt(int n);
        repeat (n) @(negedge clk);
    endtask
    task t_enable;
        on = 2'b11;
        // Channel 0 may sit in a test pulse when switched on, so allow for it
        wt(30);
        chk("supply", 6'h1, {5'h0, sup});
        chk("dout", 6'h1, {5'h0, dout});
        chk("sw_out", 6'h2a, sw);
        $display("t_enable done");
    endtask
    task t_pulse;
        // Pulses exactly at the filter limit
        pw = 20;
        repeat (300) begin
            wt(1);
            chk("removal", 6'h0, {5'h0, rem});
        end
        map = 0;
        wt(2);
        chk("dout", 6'h0, {5'h0, dout});
        $display("t_pulse done");
    endtask
    task t_chan;
        for (int c = 0; c < 2; c++) begin
            // Normal stop first, then enable is removed
            cmd = 6'h00;
            wt(2);
            chk("sw_out", 6'h00, sw);
            on = 2'b11 ^ (2'b01 << c);
            // Control keeps commanding while disabled; nothing may pass
            cmd = 6'h3f;
            wt(40);
            chk("removal", 6'h1, {5'h0, rem});
            chk("sw_out", 6'h0, sw);
            on = 2'b11;
            cmd = 6'h15 << c;
            wt(15);
            chk("sw_out", 6'h15 << c, sw);
        end
        $display("t_chan done");
    endtask
    task t_reset;
        resetn = 0;
        wt(1);
        chk("removal", 6'h1, {5'h0, rem});
        chk("sw_out", 6'h0, sw);
        chk("monitor", 6'h0, {5'h0, mon});
        resetn = 1;
        wt(2);
        chk("supply", 6'h0, {5'h0, sup});
        // Channel 1 test pulse may delay the restart by its width
        wt(30);
        chk("supply", 6'h1, {5'h0, sup});
        chk("monitor", 6'h1, {5'h0, mon});
        $display("t_reset done");
    endtask
    task t_stuck;
        pw = 0;
        wt(260);
        chk("removal", 6'h1, {5'h0, rem});
        $display("t_stuck done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        wt(3);
        resetn = 1;
        t_enable;
        t_pulse;
        t_chan;
        t_reset;
        t_stuck;
        end_of_test;
    end
    initial begin
        #30000;
        failures++;
        end_of_test;
    end
endmodule
